// File: verilog/hmss_pkg.sv
package hmss_pkg;

   // Host interface modes decoded from the three strap bits.
   typedef enum logic [1:0] {
      HMSS_MODE_NONE,
      HMSS_MODE_SPI,
      HMSS_MODE_PAR_A,
      HMSS_MODE_PAR_B
   } hmss_mode_t;

   localparam int         HMSS_STRAP_W      = 3;
   localparam logic [2:0] HMSS_STRAP_SPI    = 3'h5;
   localparam logic [2:0] HMSS_STRAP_PAR_A  = 3'h6;
   localparam logic [2:0] HMSS_STRAP_PAR_B  = 3'h7;
   localparam logic [2:0] HMSS_STRAP_RST    = 3'h0;
   localparam logic [1:0] HMSS_SETTLE_LAST  = 2'h3;
   localparam int         HMSS_PLL_CFG_W    = 16;
   localparam logic [15:0] HMSS_PLL_CFG_RST = 16'h0000;

   // Captured selection for one core.
   typedef struct packed {
      hmss_mode_t mode;
      logic       valid;
      logic       parallel;
   } hmss_sel_t;

endpackage : hmss_pkg

// File: verilog/hmss_core_port.sv
`timescale 1ns/1ns
// Per-core strap synchroniser, capture and open-drain request driver.
module hmss_core_port
   import hmss_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    arst_n,
   input  wire logic                    capture,
   input  wire logic                    small_pkg,
   input  wire logic [HMSS_STRAP_W-1:0] strap_pin,
   input  wire logic                    request,
   output hmss_sel_t                    sel,
   output logic                         request_n_o,
   output logic                         request_n_oe
);

   logic [HMSS_STRAP_W-1:0] sync1_ff, sync2_ff, sync3_ff, nxt_sync1, nxt_sync2, nxt_sync3;
   logic [HMSS_STRAP_W-1:0] stable_ff, nxt_stable;
   hmss_sel_t               sel_ff, nxt_sel;

   // Decode a strap pattern; the small package only admits the serial mode.
   function automatic hmss_sel_t decode(input logic [HMSS_STRAP_W-1:0] s, input logic sp);
      hmss_sel_t r;
      r = '{mode: HMSS_MODE_NONE, valid: 1'b0, parallel: 1'b0};
      case (s)
         HMSS_STRAP_SPI:   r = '{mode: HMSS_MODE_SPI, valid: 1'b1, parallel: 1'b0};
         HMSS_STRAP_PAR_A: if (!sp) r = '{mode: HMSS_MODE_PAR_A, valid: 1'b1, parallel: 1'b1};
         HMSS_STRAP_PAR_B: if (!sp) r = '{mode: HMSS_MODE_PAR_B, valid: 1'b1, parallel: 1'b1};
         default:          r = '{mode: HMSS_MODE_NONE, valid: 1'b0, parallel: 1'b0};
      endcase
      return r;
   endfunction : decode

   // Three-stage synchroniser; a value counts once stages two and three agree.
   always_comb
   begin
      nxt_sync1  = strap_pin;
      nxt_sync2  = sync1_ff;
      nxt_sync3  = sync2_ff;
      nxt_stable = (sync2_ff == sync3_ff) ? sync3_ff : stable_ff;
      nxt_sel    = capture ? decode(stable_ff, small_pkg) : sel_ff;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_ff  <= HMSS_STRAP_RST;
         sync2_ff  <= HMSS_STRAP_RST;
         sync3_ff  <= HMSS_STRAP_RST;
         stable_ff <= HMSS_STRAP_RST;
         sel_ff    <= '{mode: HMSS_MODE_NONE, valid: 1'b0, parallel: 1'b0};
      end
      else
      begin
         sync1_ff  <= nxt_sync1;
         sync2_ff  <= nxt_sync2;
         sync3_ff  <= nxt_sync3;
         stable_ff <= nxt_stable;
         sel_ff    <= nxt_sel;
      end
   end

   assign sel = sel_ff;

   // Open drain: only ever pull low, never drive high.
   assign request_n_o  = 1'b0;
   assign request_n_oe = request & sel_ff.valid;

endmodule : hmss_core_port

// File: verilog/hmss_strap_select.sv
`timescale 1ns/1ns
// Function
// - Capture each core's straps at reset release.
// - Decoder: 101 SPI, 110/111 parallel styles.
// - Post core: own straps, same encoding.
// - Each core has its own port.
// - Small package: serial mode only.
// - Strap pins become run-time functions afterwards.
// - Request outputs are open drain always.
// - PLL configured by decoder core software.
// - Unused parallel pins stay high-impedance inputs.
module hmss_strap_select
   import hmss_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      arst_n,
   input  wire logic                      small_pkg,
   input  wire logic [HMSS_STRAP_W-1:0]   decoder_host_mode_strap,
   input  wire logic [HMSS_STRAP_W-1:0]   post_host_mode_strap,
   input  wire logic                      decoder_request,
   input  wire logic                      post_request,
   input  wire logic [HMSS_STRAP_W-1:0]   decoder_alt_out,
   input  wire logic [HMSS_STRAP_W-1:0]   post_alt_out,
   input  wire logic [HMSS_STRAP_W-1:0]   decoder_alt_oe,
   input  wire logic [HMSS_STRAP_W-1:0]   post_alt_oe,
   input  wire logic                      decoder_par_drive,
   input  wire logic                      post_par_drive,
   input  wire logic                      pll_cfg_we,
   input  wire logic [HMSS_PLL_CFG_W-1:0] pll_cfg_wdata,
   output hmss_sel_t                      decoder_sel,
   output hmss_sel_t                      post_sel,
   output logic                           strap_phase,
   output logic [HMSS_STRAP_W-1:0]        decoder_strap_pin_o,
   output logic [HMSS_STRAP_W-1:0]        decoder_strap_pin_oe,
   output logic [HMSS_STRAP_W-1:0]        post_strap_pin_o,
   output logic [HMSS_STRAP_W-1:0]        post_strap_pin_oe,
   output logic                           decoder_par_oe,
   output logic                           post_par_oe,
   output logic                           modes_match,
   output logic [HMSS_PLL_CFG_W-1:0]      pll_cfg,
   output logic                           decoder_request_n_o,
   output logic                           decoder_request_n_oe,
   output logic                           post_request_n_o,
   output logic                           post_request_n_oe
);

   logic                      phase_ff, nxt_phase;
   logic                      cap_ff, nxt_cap;
   logic [1:0]                wait_ff, nxt_wait;
   logic [HMSS_PLL_CFG_W-1:0] pll_ff, nxt_pll;

   // After reset release, wait for the three-stage synchronisers to settle,
   // then capture once in a single-cycle pulse and leave the strap phase.
   always_comb
   begin
      nxt_wait  = wait_ff;
      nxt_cap   = 1'b0;
      nxt_phase = phase_ff;
      if (phase_ff)
      begin
         if (wait_ff == HMSS_SETTLE_LAST)
         begin
            nxt_cap   = 1'b1;
            nxt_phase = 1'b0;
         end
         else
            nxt_wait = wait_ff + 2'h1;
      end
   end

   // Registers only; every decision sits in the process above, so the
   // capture timing can be read in one place.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wait_ff  <= 2'h0;
         cap_ff   <= 1'b0;
         phase_ff <= 1'b1;
      end
      else
      begin
         wait_ff  <= nxt_wait;
         cap_ff   <= nxt_cap;
         phase_ff <= nxt_phase;
      end
   end

   // PLL configuration is written only by the decoder core's software.
   always_comb
   begin
      nxt_pll = pll_cfg_we ? pll_cfg_wdata : pll_ff;
   end

   // The configuration survives everything but reset; software must rewrite
   // it after every reset before the derived clocks are trusted.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         pll_ff <= HMSS_PLL_CFG_RST;
      else
         pll_ff <= nxt_pll;
   end

   assign pll_cfg     = pll_ff;
   assign strap_phase = phase_ff;

   // Each core gets its own independent capture and request driver.
   hmss_core_port u_decoder (
      .clk          (clk),
      .arst_n       (arst_n),
      .capture      (cap_ff),
      .small_pkg    (small_pkg),
      .strap_pin    (decoder_host_mode_strap),
      .request      (decoder_request),
      .sel          (decoder_sel),
      .request_n_o  (decoder_request_n_o),
      .request_n_oe (decoder_request_n_oe)
   );

   hmss_core_port u_post (
      .clk          (clk),
      .arst_n       (arst_n),
      .capture      (cap_ff),
      .small_pkg    (small_pkg),
      .strap_pin    (post_host_mode_strap),
      .request      (post_request),
      .sel          (post_sel),
      .request_n_o  (post_request_n_o),
      .request_n_oe (post_request_n_oe)
   );

   // Strap pins are inputs while straps are live, then the run-time function owns them.
   assign decoder_strap_pin_o  = decoder_alt_out;
   assign post_strap_pin_o     = post_alt_out;
   assign decoder_strap_pin_oe = phase_ff ? '0 : decoder_alt_oe;
   assign post_strap_pin_oe    = phase_ff ? '0 : post_alt_oe;

   // Parallel pins never drive unless a parallel mode was captured.
   assign decoder_par_oe = decoder_sel.parallel & decoder_par_drive;
   assign post_par_oe    = post_sel.parallel & post_par_drive;

   // The board is trusted to strap both alike; this flag merely reports it.
   assign modes_match = (decoder_sel.mode == post_sel.mode);

   // The capture walk in steps: the settle counter reaches its last count
   // while the straps are still live, then a single capture pulse fires with
   // the strap phase already over, then nothing moves again until reset.
   sequence seq_settle_done;
      phase_ff && (wait_ff == HMSS_SETTLE_LAST);
   endsequence

   sequence seq_capture_fire;
      cap_ff && !phase_ff;
   endsequence

   sequence seq_run_quiet;
      !cap_ff && !phase_ff;
   endsequence

   // Selection, capture, PLL and pin-driver checks; every one is off while reset is low.
   chk_mode_held: assert property (@(posedge clk) disable iff (!arst_n)
      !cap_ff |=> $stable(decoder_sel) && $stable(post_sel))
      else $error("mode changed without capture");
   chk_small_spi: assert property (@(posedge clk) disable iff (!arst_n)
      small_pkg |-> !decoder_sel.parallel && !post_sel.parallel)
      else $error("parallel mode in small package");
   chk_od_low: assert property (@(posedge clk) disable iff (!arst_n)
      !decoder_request_n_o && !post_request_n_o)
      else $error("request driven high");
   chk_par_float: assert property (@(posedge clk) disable iff (!arst_n)
      !decoder_sel.parallel |-> !decoder_par_oe)
      else $error("parallel pin driven outside parallel mode");
   chk_strap_input: assert property (@(posedge clk) disable iff (!arst_n)
      phase_ff |-> decoder_strap_pin_oe == '0 && post_strap_pin_oe == '0)
      else $error("strap pin driven during strap phase");
   chk_cap_once: assert property (@(posedge clk) disable iff (!arst_n)
      cap_ff |=> !cap_ff [*4])
      else $error("capture repeated");
   chk_pll_write: assert property (@(posedge clk) disable iff (!arst_n)
      pll_cfg_we |=> pll_cfg == $past(pll_cfg_wdata))
      else $error("pll config not written");
   chk_post_od: assert property (@(posedge clk) disable iff (!arst_n)
      !post_sel.valid |-> !post_request_n_oe)
      else $error("post request pulled without mode");

   // Capture ordering built from the steps above.
   chk_cap_walk: assert property (@(posedge clk) disable iff (!arst_n)
      seq_settle_done |=> seq_capture_fire)
      else $error("capture did not follow the settle count");
   chk_cap_last: assert property (@(posedge clk) disable iff (!arst_n)
      seq_capture_fire |=> seq_run_quiet)
      else $error("strap phase reopened after capture");
   chk_phase_stays: assert property (@(posedge clk) disable iff (!arst_n)
      !phase_ff |=> !phase_ff)
      else $error("strap phase restarted without reset");

   // Pin drivers of both cores, PLL hold and selection flag consistency.
   chk_alt_drive: assert property (@(posedge clk) disable iff (!arst_n)
      !phase_ff |-> (decoder_strap_pin_oe == decoder_alt_oe)
                    && (post_strap_pin_oe == post_alt_oe))
      else $error("run-time pin drive not passed through");
   chk_post_float: assert property (@(posedge clk) disable iff (!arst_n)
      !post_sel.parallel |-> !post_par_oe)
      else $error("post parallel pin driven outside parallel mode");
   chk_dec_od: assert property (@(posedge clk) disable iff (!arst_n)
      !decoder_sel.valid |-> !decoder_request_n_oe)
      else $error("decoder request pulled without mode");
   chk_dec_pull: assert property (@(posedge clk) disable iff (!arst_n)
      decoder_request && decoder_sel.valid |-> decoder_request_n_oe)
      else $error("decoder request not pulled low");
   chk_post_pull: assert property (@(posedge clk) disable iff (!arst_n)
      post_request && post_sel.valid |-> post_request_n_oe)
      else $error("post request not pulled low");
   chk_pll_hold: assert property (@(posedge clk) disable iff (!arst_n)
      !pll_cfg_we |=> $stable(pll_cfg))
      else $error("pll config changed without a write");
   chk_valid_mode: assert property (@(posedge clk) disable iff (!arst_n)
      decoder_sel.valid == (decoder_sel.mode != HMSS_MODE_NONE)
      && post_sel.valid == (post_sel.mode != HMSS_MODE_NONE))
      else $error("valid flag disagrees with mode");
   chk_par_mode: assert property (@(posedge clk) disable iff (!arst_n)
      decoder_sel.parallel |-> decoder_sel.mode inside {HMSS_MODE_PAR_A, HMSS_MODE_PAR_B})
      else $error("parallel flag without a parallel mode");

endmodule : hmss_strap_select

// File: tb/hmss_board_model.sv
`timescale 1ns/1ns
// Board straps and host pull-ups; a pin that the device drives wins over its resistor.
module hmss_board_model
   import hmss_pkg::*;
(
   input  wire logic [2:0] dec_strap,
   input  wire logic [2:0] post_strap,
   input  wire logic [2:0] dec_o,
   input  wire logic [2:0] dec_oe,
   input  wire logic [2:0] post_o,
   input  wire logic [2:0] post_oe,
   input  wire logic       dec_rq_o,
   input  wire logic       dec_rq_oe,
   input  wire logic       post_rq_o,
   input  wire logic       post_rq_oe,
   output logic      [2:0] dec_pin,
   output logic      [2:0] post_pin,
   output logic            dec_line,
   output logic            post_line
);
   // Strap resistors hold each pin level until the running core drives it.
   assign dec_pin   = (dec_oe & dec_o) | (~dec_oe & dec_strap);
   assign post_pin  = (post_oe & post_o) | (~post_oe & post_strap);
   // No party drives the request lines high, so the pull-up gives that level.
   assign dec_line  = dec_rq_oe ? dec_rq_o : 1'b1;
   assign post_line = post_rq_oe ? post_rq_o : 1'b1;
endmodule : hmss_board_model

// File: tb/tb.sv
`timescale 1ns/1ns
// Self-checking bench for the strap selector.
module tb
   import hmss_pkg::*;
;
   logic       clk, arst_n, small_pkg, dec_rq, post_rq, dec_pd, post_pd, pll_we;
   logic [2:0] dec_strap, post_strap, dec_ao, post_ao, dec_aoe, post_aoe, dec_pin, post_pin;
   logic [2:0] dec_po, dec_poe, post_po, post_poe;
   logic       phase, dec_poe1, post_poe1, match, drn_o, drn_oe, prn_o, prn_oe;
   logic       dec_line, post_line;
   logic [15:0] pll_wd, pll_cfg;
   hmss_sel_t  dec_sel, post_sel;
   int         n_fail, n_checks;

   hmss_strap_select dut (.clk(clk), .arst_n(arst_n), .small_pkg(small_pkg),
      .decoder_host_mode_strap(dec_pin), .post_host_mode_strap(post_pin),
      .decoder_request(dec_rq), .post_request(post_rq), .decoder_alt_out(dec_ao),
      .post_alt_out(post_ao), .decoder_alt_oe(dec_aoe), .post_alt_oe(post_aoe),
      .decoder_par_drive(dec_pd), .post_par_drive(post_pd), .pll_cfg_we(pll_we),
      .pll_cfg_wdata(pll_wd), .decoder_sel(dec_sel), .post_sel(post_sel),
      .strap_phase(phase), .decoder_strap_pin_o(dec_po), .decoder_strap_pin_oe(dec_poe),
      .post_strap_pin_o(post_po), .post_strap_pin_oe(post_poe), .decoder_par_oe(dec_poe1),
      .post_par_oe(post_poe1), .modes_match(match), .pll_cfg(pll_cfg),
      .decoder_request_n_o(drn_o), .decoder_request_n_oe(drn_oe),
      .post_request_n_o(prn_o), .post_request_n_oe(prn_oe));

   hmss_board_model board (.dec_strap(dec_strap), .post_strap(post_strap), .dec_o(dec_po),
      .dec_oe(dec_poe), .post_o(post_po), .post_oe(post_poe), .dec_rq_o(drn_o),
      .dec_rq_oe(drn_oe), .post_rq_o(prn_o), .post_rq_oe(prn_oe), .dec_pin(dec_pin),
      .post_pin(post_pin), .dec_line(dec_line), .post_line(post_line));

   // Free-running 20 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic end_of_test();
      if (n_fail == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   function automatic hmss_mode_t exp_mode(logic [2:0] p, logic s);
      if (p === HMSS_STRAP_SPI) return HMSS_MODE_SPI;
      if (p === HMSS_STRAP_PAR_A && !s) return HMSS_MODE_PAR_A;
      if (p === HMSS_STRAP_PAR_B && !s) return HMSS_MODE_PAR_B;
      return HMSS_MODE_NONE;
   endfunction : exp_mode

   task automatic chk_sel(hmss_sel_t g, logic [2:0] p, logic s);
      hmss_mode_t m;
      m = exp_mode(p, s);
      chk("mode", 32'(m), 32'(g.mode));
      chk("valid", 32'(m != HMSS_MODE_NONE), 32'(g.valid));
      chk("parallel", 32'(m == HMSS_MODE_PAR_A || m == HMSS_MODE_PAR_B), 32'(g.parallel));
   endtask : chk_sel

   // Reset with the given straps, check reset state, release and wait for capture.
   task automatic boot(logic [2:0] d, logic [2:0] p, logic s);
      int i;
      @(posedge clk);
      arst_n <= 1'b0;
      dec_strap <= d;
      post_strap <= p;
      small_pkg <= s;
      repeat (5) @(posedge clk);
      #1;
      chk("phase_rst", 1, phase);
      chk("sel_rst", 0, {dec_sel, post_sel});
      chk("oe_rst", 0, {dec_poe, post_poe, dec_poe1, post_poe1});
      chk("pll_rst", 0, pll_cfg);
      @(posedge clk);
      arst_n <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         #1;
         if (phase === 1'b0) break;
      end
      if (i == 20)
      begin
         chk("phase_wait", 0, 1);
         end_of_test();
      end
      @(posedge clk);
      #1;
   endtask : boot

   // Every strap pattern on both cores, in both packages.
   task automatic t_table();
      for (int s = 0; s < 2; s++)
         for (int p = 0; p < 8; p++)
         begin
            boot(3'(p), 3'(p), 1'(s));
            chk_sel(dec_sel, 3'(p), 1'(s));
            chk_sel(post_sel, 3'(p), 1'(s));
            chk("match", 1, match);
         end
   endtask : t_table

   // Separate modes, straps moving after capture, run-time pins and requests.
   task automatic t_run();
      boot(3'h5, 3'h6, 1'b0);
      @(posedge clk);
      dec_strap <= 3'h7;
      post_strap <= 3'h5;
      dec_aoe <= 3'h7;
      dec_ao <= 3'h2;
      post_aoe <= 3'h1;
      post_ao <= 3'h1;
      dec_pd <= 1'b1;
      post_pd <= 1'b1;
      dec_rq <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk_sel(dec_sel, 3'h5, 1'b0);
      chk_sel(post_sel, 3'h6, 1'b0);
      chk("match", 0, match);
      chk("alt", {3'h2, 3'h7, 3'h1, 3'h1}, {dec_po, dec_poe, post_po, post_poe});
      chk("par_oe", 2'h1, {dec_poe1, post_poe1});
      chk("lines", 2'h1, {dec_line, post_line});
      chk("req", 4'h4, {drn_o, drn_oe, prn_o, prn_oe});
      @(posedge clk);
      dec_rq <= 1'b0;
      post_rq <= 1'b1;
      @(posedge clk);
      #1;
      chk("lines2", 2'h2, {dec_line, post_line});
   endtask : t_run

   // Unsupported pattern on both cores: no request drive and no parallel pin drive after capture.
   task automatic t_none();
      boot(3'h2, 3'h4, 1'b0);
      @(posedge clk);
      dec_rq <= 1'b1;
      @(posedge clk);
      #1;
      chk("req_none", 2'h0, {drn_oe, prn_oe});
      chk("par_none", 2'h0, {dec_poe1, post_poe1});
   endtask : t_none

   // Back-to-back configuration writes, then a hold.
   task automatic t_pll();
      @(posedge clk);
      pll_we <= 1'b1;
      pll_wd <= 16'h1234;
      @(posedge clk);
      pll_wd <= 16'hABCD;
      #1;
      chk("pll1", 16'h1234, pll_cfg);
      @(posedge clk);
      pll_we <= 1'b0;
      pll_wd <= 16'h5A5A;
      #1;
      chk("pll2", 16'hABCD, pll_cfg);
      repeat (2) @(posedge clk);
      #1;
      chk("pll3", 16'hABCD, pll_cfg);
   endtask : t_pll

   // Main sequence.
   initial
   begin
      {arst_n, small_pkg, dec_rq, post_rq, dec_pd, post_pd, pll_we} = '0;
      {dec_strap, post_strap, dec_ao, post_ao, dec_aoe, post_aoe} = '0;
      pll_wd = 16'h0000;
      n_fail = 0;
      n_checks = 0;
      t_table();
      t_run();
      t_pll();
      t_none();
      end_of_test();
   end
endmodule : tb
